// *** pio_top.sv ***
// parallel i/o block: three ports, control word and interrupt gating
`timescale 1ns/10ps
module pio_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // host register port
  input wire pio_pkg::pio_host_req_t host_req,
  output logic [pio_pkg::DATA_W-1:0] host_rdata,
  output logic host_rvalid,
  // parallel lines
  input wire pio_pkg::pio_pins_t pin_in,
  output pio_pkg::pio_pins_t pin_out,
  output pio_pkg::pio_pins_t pin_oe,
  // host interrupt request
  output logic service_request_line,
  output logic service_request_oe
);
  import pio_pkg::*;

  pio_pins_t sync1_q, sync2_q, prev_q;
  pio_cfg_t cfg_q;
  logic [DATA_W-1:0] port_a_data_q, port_b_data_q, port_c_data_q;
  logic [DATA_W-1:0] latch_a_q, latch_b_q;
  logic ibf_a_q, ibf_b_q, obf_a_q, obf_b_q, done_a_q, done_b_q;
  logic group_a_irq_q, group_b_irq_q;
  logic group_a_irq_select_q, group_b_irq_select_q, master_irq_enable_q;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q, sreq_q, sreq_oe_q;
  pio_pins_t pout_q, poe_q, pout_d, poe_d;

  pio_mode_t mode_a;
  logic b_hs, a_in_side, a_out_side, b_in_side, b_out_side;
  logic wr_a, wr_b, wr_c, wr_ctrl, mode_set, bit_op, rd_a, rd_b;
  logic stb_a_fall, ack_a_fall, stb_b_fall, ack_b_fall;
  logic group_a_irq_d, group_b_irq_d;
  logic [DATA_W-1:0] rdata_d;

  // pins come from outside the clock domain; only sync2 feeds logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign mode_a = pio_mode_a(cfg_q.a_mode);
  assign b_hs = cfg_q.b_mode;
  // port A takes input in mode 1 input or mode 2, output likewise
  assign a_in_side = (mode_a == PIO_MODE2) |
                     ((mode_a == PIO_MODE1) & cfg_q.a_in);
  assign a_out_side = (mode_a == PIO_MODE2) |
                      ((mode_a == PIO_MODE1) & ~cfg_q.a_in);
  assign b_in_side = b_hs & cfg_q.b_in;
  assign b_out_side = b_hs & ~cfg_q.b_in;

  assign wr_a = ce & host_req.wr & (host_req.addr == OFS_PORT_A);
  assign wr_b = ce & host_req.wr & (host_req.addr == OFS_PORT_B);
  assign wr_c = ce & host_req.wr & (host_req.addr == OFS_PORT_C);
  assign wr_ctrl = ce & host_req.wr & (host_req.addr == OFS_CTRL);
  assign mode_set = wr_ctrl & host_req.wdata[CW_FLAG_BIT];
  assign bit_op = wr_ctrl & ~host_req.wdata[CW_FLAG_BIT];
  assign rd_a = ce & host_req.rd & (host_req.addr == OFS_PORT_A);
  assign rd_b = ce & host_req.rd & (host_req.addr == OFS_PORT_B);

  assign stb_a_fall = pio_fell(prev_q.c[PC_STB_A], sync2_q.c[PC_STB_A]);
  assign ack_a_fall = pio_fell(prev_q.c[PC_ACK_A], sync2_q.c[PC_ACK_A]);
  assign stb_b_fall = pio_fell(prev_q.c[PC_STB_B], sync2_q.c[PC_STB_B]);
  assign ack_b_fall = pio_fell(prev_q.c[PC_STB_B], sync2_q.c[PC_STB_B]);

  // group configuration; reset leaves every line an input in mode 0
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (mode_set) begin
      cfg_q <= pio_cfg_t'(host_req.wdata[CW_FLAG_BIT-1:0]);
    end
  end

  // written port values; output lines keep them until rewritten or a mode word clears them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_a_data_q <= PORT_RESET;
      port_b_data_q <= PORT_RESET;
      port_c_data_q <= PORT_RESET;
    end else if (mode_set) begin
      port_a_data_q <= PORT_RESET;
      port_b_data_q <= PORT_RESET;
      port_c_data_q <= PORT_RESET;
    end else begin
      if (wr_a) begin
        port_a_data_q <= host_req.wdata;
      end
      if (wr_b) begin
        port_b_data_q <= host_req.wdata;
      end
      if (wr_c) begin
        port_c_data_q <= host_req.wdata;
      end else if (bit_op) begin
        // bits 6..4 are don't care; a bit on a strobe input is its enable
        port_c_data_q[host_req.wdata[BSR_IDX_HI:BSR_IDX_LO]] <=
          host_req.wdata[BSR_VAL_BIT];
      end
    end
  end

  // group A handshake; a strobe in the same cycle as a read keeps ibf
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_a_q <= PORT_RESET;
      ibf_a_q <= 1'b0;
      obf_a_q <= 1'b0;
      done_a_q <= 1'b0;
    end else if (mode_set) begin
      ibf_a_q <= 1'b0;
      obf_a_q <= 1'b0;
      done_a_q <= 1'b0;
    end else if (ce) begin
      if (a_in_side & stb_a_fall) begin
        latch_a_q <= sync2_q.a;
        ibf_a_q <= 1'b1;
      end else if (rd_a & a_in_side) begin
        ibf_a_q <= 1'b0;
      end
      if (a_out_side & ack_a_fall) begin
        obf_a_q <= 1'b0;
        done_a_q <= 1'b1;
      end else if (wr_a & a_out_side) begin
        obf_a_q <= 1'b1;
        done_a_q <= 1'b0;
      end
    end
  end

  // group B handshake, mode 1 only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_b_q <= PORT_RESET;
      ibf_b_q <= 1'b0;
      obf_b_q <= 1'b0;
      done_b_q <= 1'b0;
    end else if (mode_set) begin
      ibf_b_q <= 1'b0;
      obf_b_q <= 1'b0;
      done_b_q <= 1'b0;
    end else if (ce) begin
      if (b_in_side & stb_b_fall) begin
        latch_b_q <= sync2_q.b;
        ibf_b_q <= 1'b1;
      end else if (rd_b & b_in_side) begin
        ibf_b_q <= 1'b0;
      end
      if (b_out_side & ack_b_fall) begin
        obf_b_q <= 1'b0;
        done_b_q <= 1'b1;
      end else if (wr_b & b_out_side) begin
        obf_b_q <= 1'b1;
        done_b_q <= 1'b0;
      end
    end
  end

  // service requests: data waiting or buffer drained, strobe or acknowledge released
  always_comb begin
    group_a_irq_d = 1'b0;
    unique case (mode_a)
      PIO_MODE0: group_a_irq_d = 1'b0;
      PIO_MODE1: begin
        if (cfg_q.a_in) begin
          group_a_irq_d = ibf_a_q & sync2_q.c[PC_STB_A] &
                          port_c_data_q[PC_STB_A];
        end else begin
          group_a_irq_d = done_a_q & sync2_q.c[PC_ACK_A] &
                          port_c_data_q[PC_ACK_A];
        end
      end
      PIO_MODE2: begin
        group_a_irq_d = (done_a_q & sync2_q.c[PC_ACK_A] &
                         port_c_data_q[PC_ACK_A]) |
                        (ibf_a_q & sync2_q.c[PC_STB_A] &
                         port_c_data_q[PC_STB_A]);
      end
    endcase
    group_b_irq_d = b_hs & port_c_data_q[PC_STB_B] & sync2_q.c[PC_STB_B] &
                    (cfg_q.b_in ? ibf_b_q : done_b_q);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      group_a_irq_q <= 1'b0;
      group_b_irq_q <= 1'b0;
    end else if (ce) begin
      group_a_irq_q <= group_a_irq_d;
      group_b_irq_q <= group_b_irq_d;
    end
  end

  // interrupt control registers; only defined bits are stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      group_a_irq_select_q <= 1'b0;
      group_b_irq_select_q <= 1'b0;
      master_irq_enable_q <= 1'b0;
    end else if (ce & host_req.wr) begin
      if (host_req.addr == OFS_IRQ_SEL) begin
        group_a_irq_select_q <= host_req.wdata[SEL_A_BIT];
        group_b_irq_select_q <= host_req.wdata[SEL_B_BIT];
      end
      if (host_req.addr == OFS_IRQ_GATE) begin
        master_irq_enable_q <= host_req.wdata[GATE_EN_BIT];
      end
    end
  end

  // the host line is shared, so it floats unless the master enable is on
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sreq_q <= 1'b0;
      sreq_oe_q <= 1'b0;
    end else if (ce) begin
      sreq_q <= master_irq_enable_q &
                ((group_a_irq_select_q & group_a_irq_q) |
                 (group_b_irq_select_q & group_b_irq_q));
      sreq_oe_q <= master_irq_enable_q;
    end
  end

  // line drive; undriven inputs rely on board pull-ups
  always_comb begin
    pout_d.a = port_a_data_q;
    pout_d.b = port_b_data_q;
    pout_d.c = port_c_data_q;
    poe_d.a = {DATA_W{~cfg_q.a_in}};
    poe_d.b = {DATA_W{~cfg_q.b_in}};
    poe_d.c = {{NIBBLE_W{~cfg_q.cu_in}}, {NIBBLE_W{~cfg_q.cl_in}}};
    if (mode_a == PIO_MODE2) begin
      // bidirectional bus is driven only while the peer acknowledges
      poe_d.a = {DATA_W{~sync2_q.c[PC_ACK_A]}};
    end
    if (b_hs) begin
      poe_d.c[PC_SERVICE_REQUEST_LINE_B] = 1'b1;
      pout_d.c[PC_SERVICE_REQUEST_LINE_B] = group_b_irq_q;
      poe_d.c[PC_FLAG_B] = 1'b1;
      pout_d.c[PC_FLAG_B] = cfg_q.b_in ? ibf_b_q : ~obf_b_q;
      poe_d.c[PC_STB_B] = 1'b0;
    end
    if (mode_a != PIO_MODE0) begin
      poe_d.c[PC_SERVICE_REQUEST_LINE_A] = 1'b1;
      pout_d.c[PC_SERVICE_REQUEST_LINE_A] = group_a_irq_q;
    end
    if (a_in_side) begin
      poe_d.c[PC_STB_A] = 1'b0;
      poe_d.c[PC_IBF_A] = 1'b1;
      pout_d.c[PC_IBF_A] = ibf_a_q;
    end
    if (a_out_side) begin
      poe_d.c[PC_ACK_A] = 1'b0;
      poe_d.c[PC_OBF_A] = 1'b1;
      pout_d.c[PC_OBF_A] = ~obf_a_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pout_q <= '0;
      poe_q <= '0;
    end else if (ce) begin
      pout_q <= pout_d;
      poe_q <= poe_d;
    end
  end

  // read data; write-only and unmapped offsets return zero
  always_comb begin
    rdata_d = RDATA_NONE;
    if (host_req.addr == OFS_PORT_A) begin
      rdata_d = a_in_side ? latch_a_q :
                (cfg_q.a_in ? sync2_q.a : port_a_data_q);
    end else if (host_req.addr == OFS_PORT_B) begin
      rdata_d = b_in_side ? latch_b_q :
                (cfg_q.b_in ? sync2_q.b : port_b_data_q);
    end else if (host_req.addr == OFS_PORT_C) begin
      rdata_d = (pout_q.c & poe_q.c) | (sync2_q.c & ~poe_q.c);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RDATA_NONE;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= host_req.rd;
      if (host_req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign host_rdata = rdata_q;
  assign host_rvalid = rvalid_q;
  assign pin_out = pout_q;
  assign pin_oe = poe_q;
  assign service_request_line = sreq_q;
  assign service_request_oe = sreq_oe_q;

endmodule : pio_top

// *** pio_pkg.sv ***
// constants, types and helpers for the 24-line parallel i/o block
// Function
// - twenty-four i/o lines form three 8-bit ports A, B and C.
// - group A is port A plus upper C; group B is B plus lower C.
// - configurable as two handshaking ports or plain 8+8+4+4 line ports.
// - ports A, B, C at offsets 00, 01, 02; control word at 03.
// - two write-only 8-bit interrupt control registers at offsets 14 and 15.
// - control word with bit 7 set programs group modes and directions.
// - control word with bit 7 clear leaves modes, sets or clears a C bit.
// - bits 3..1 pick the port C bit, bit 0 is its value.
// - group B request reaches host only with its select and master enable.
// - group A request reaches host only with its select and master enable.
// - a cleared select blocks that group whatever the master enable.
// - bit 2 of the second interrupt register is the master enable.
// - with master enable clear the host request line is not driven.
// - reserved interrupt register bits are ignored when written as ones.
// - group B request needs its internal enable set.
// - group A needs its enable in mode 1, either bidir enable in mode 2.
// - handshaked transfers raise a group request when service is needed.
// - output lines hold the last written value until a mode word clears it; inputs left undriven.
package pio_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_PORT_A = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_B = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_PORT_C = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SEL = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_GATE = 5'h15;

  localparam int CW_FLAG_BIT = 7;
  localparam int SEL_A_BIT = 0;
  localparam int SEL_B_BIT = 1;
  localparam int GATE_EN_BIT = 2;

  // single-bit command fields of the control word
  localparam int BSR_IDX_HI = 3;
  localparam int BSR_IDX_LO = 1;
  localparam int BSR_VAL_BIT = 0;
  localparam int NIBBLE_W = 4;

  // port C line roles while a group handshakes
  localparam int PC_SERVICE_REQUEST_LINE_B = 0;
  localparam int PC_FLAG_B = 1;
  localparam int PC_STB_B = 2;
  localparam int PC_SERVICE_REQUEST_LINE_A = 3;
  localparam int PC_STB_A = 4;
  localparam int PC_IBF_A = 5;
  localparam int PC_ACK_A = 6;
  localparam int PC_OBF_A = 7;

  localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
  localparam logic [DATA_W-1:0] PORT_RESET = 8'h00;

  typedef enum logic [2:0] {
    PIO_MODE0 = 3'h1,
    PIO_MODE1 = 3'h2,
    PIO_MODE2 = 3'h4
  } pio_mode_t;

  // field order matches control word bits 6..0
  typedef struct packed {
    logic [1:0] a_mode;
    logic a_in;
    logic cu_in;
    logic b_mode;
    logic b_in;
    logic cl_in;
  } pio_cfg_t;

  localparam pio_cfg_t CFG_RESET = 7'h1B;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pio_host_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] c;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] a;
  } pio_pins_t;

  function automatic pio_mode_t pio_mode_a(input logic [1:0] f);
    if (f[1]) begin
      return PIO_MODE2;
    end else if (f[0]) begin
      return PIO_MODE1;
    end
    return PIO_MODE0;
  endfunction : pio_mode_a

  function automatic logic pio_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : pio_fell

endpackage : pio_pkg

// *** pio_checker.sv ***
// assertion checker for the parallel i/o block
`timescale 1ns/10ps
module pio_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // host side
  input wire pio_pkg::pio_host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  // lines and interrupt
  input wire pio_pkg::pio_pins_t pin_in,
  input wire pio_pkg::pio_pins_t pin_out,
  input wire pio_pkg::pio_pins_t pin_oe,
  input wire logic service_request_line,
  input wire logic service_request_oe
);
  import pio_pkg::*;
  logic wr_gate;
  logic wr_ctrl;
  logic wr_a;
  logic rd_wo;
  assign wr_gate = ce && host_req.wr && host_req.addr == OFS_IRQ_GATE;
  assign wr_ctrl = ce && host_req.wr && host_req.addr == OFS_CTRL;
  assign wr_a = ce && host_req.wr && host_req.addr == OFS_PORT_A;
  assign rd_wo = ce && host_req.rd && (host_req.addr == OFS_CTRL ||
    host_req.addr == OFS_IRQ_SEL || host_req.addr == OFS_IRQ_GATE);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_gate(logic b);
    wr_gate && host_req.wdata[GATE_EN_BIT] == b ##1 !wr_gate;
  endsequence
  sequence s_ctrl(logic [7:0] v);
    wr_ctrl && host_req.wdata == v ##1 !wr_ctrl;
  endsequence
  a_master_on: assert property (s_gate(1'b1) |=> service_request_oe)
    else $error("interrupt output not enabled");
  a_master_off: assert property (s_gate(1'b0) |=> !service_request_oe)
    else $error("interrupt output still driven");
  a_line_gated: assert property (service_request_line |-> service_request_oe)
    else $error("request without enable");
  a_read_answer: assert property (ce && host_req.rd |=> host_rvalid)
    else $error("read not answered");
  a_wo_zero: assert property (rd_wo |=> host_rdata == RDATA_NONE)
    else $error("write-only register read back data");
  a_mode_out: assert property (s_ctrl(8'h80) |=> pin_oe == 24'hFFFFFF)
    else $error("mode word did not set outputs");
  a_bit_cmd: assert property (wr_ctrl && !host_req.wdata[7] ##1 !wr_ctrl
    |=> !pin_oe.c[$past(host_req.wdata[3:1], 2)] ||
    pin_out.c[$past(host_req.wdata[3:1], 2)] == $past(host_req.wdata[0], 2))
    else $error("port c bit command lost");
  a_port_a_out: assert property (wr_a ##1 !wr_a && !wr_ctrl
    |=> pin_out.a == $past(host_req.wdata, 2))
    else $error("port a output mismatch");
  a_reset_quiet: assert property ($rose(rst_n) |->
    pin_oe == '0 && !service_request_oe)
    else $error("outputs active after reset");
endmodule : pio_checker

bind pio_top pio_checker i_chk (.clock(clock), .rst_n(rst_n), .ce(ce),
  .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .service_request_line(service_request_line),
  .service_request_oe(service_request_oe));

// *** pio_line_partner.sv ***
// far-side equipment model for the parallel lines
`timescale 1ns/10ps
module pio_line_partner (
  // lines from the block
  input wire pio_pkg::pio_pins_t pin_out,
  input wire pio_pkg::pio_pins_t pin_oe,
  // equipment drive
  input wire pio_pkg::pio_pins_t ext_val,
  input wire pio_pkg::pio_pins_t ext_en,
  // levels seen by the block
  output pio_pkg::pio_pins_t pin_in
);
  import pio_pkg::*;
  // a line nobody drives floats up to the pull-up level
  assign pin_in = pio_pins_t'((pin_oe & pin_out) |
    (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en));
endmodule : pio_line_partner

// *** tb_top.sv ***
// self-checking bench for the parallel i/o block
`timescale 1ns/10ps
module tb_top;
  import pio_pkg::*;
  logic clock;
  logic rst_n;
  pio_host_req_t host_req;
  logic [7:0] host_rdata;
  logic host_rvalid;
  pio_pins_t pin_in;
  pio_pins_t pin_out;
  pio_pins_t pin_oe;
  pio_pins_t ext_val;
  pio_pins_t ext_en;
  logic irq;
  logic irq_oe;
  logic ce;
  logic [7:0] q;
  logic [7:0] exp_c;
  logic [23:0] po;
  int n_errors;
  int n_tests;
  int cycles;
  // offset, write data, expected read back
  logic [20:0] rows [6] = '{{OFS_PORT_A, 8'hA5, 8'hA5},
    {OFS_PORT_B, 8'h3C, 8'h3C}, {OFS_PORT_C, 8'h81, 8'h81},
    {OFS_IRQ_SEL, 8'hFC, 8'h00}, {OFS_IRQ_GATE, 8'hFB, 8'h00},
    {5'h1F, 8'h77, 8'h00}};

  pio_top i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
    .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .service_request_line(irq),
    .service_request_oe(irq_oe));
  pio_line_partner i_lines (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // active-low strobe pulse, then time for sync and flag update
  task automatic pulse(input int b);
    ext_val.c[b] = 1'b0;
    repeat (2) @(negedge clock);
    ext_val.c[b] = 1'b1;
    repeat (8) @(negedge clock);
  endtask : pulse

  // a quiet gap after each write lets registered outputs settle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    host_req.wr = 1'b0;
    repeat (3) @(negedge clock);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock);
    host_req.rd = 1'b0;
    chk({23'h0, host_rvalid}, 24'h1);
    d = host_rdata;
    @(negedge clock);
  endtask : rd

  task automatic conclude();
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    host_req = '0;
    ext_val = '0;
    ext_en = '0;
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(pin_oe, 24'h0);
    chk({23'h0, irq_oe}, 24'h0);
    ext_en.a = 8'hFF;
    ext_val.a = 8'h5A;
    repeat (4) @(negedge clock);
    rd(OFS_PORT_A, q);
    chk({16'h0, q}, 24'h5A);
    rd(OFS_PORT_B, q);
    chk({16'h0, q}, 24'hFF);
    wr(OFS_CTRL, 8'h80);
    chk(pin_oe, 24'hFFFFFF);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd(rows[i][20:16], q);
      chk({16'h0, q}, {16'h0, rows[i][7:0]});
      po = pin_out;
      if (rows[i][20:16] < 5'h03) begin
        chk({16'h0, po[rows[i][17:16]*8 +: 8]}, {16'h0, rows[i][7:0]});
      end
    end
    chk({23'h0, irq_oe}, 24'h0);
    wr(OFS_PORT_C, 8'h00);
    exp_c = 8'h00;
    for (int n = 0; n < 16; n++) begin
      exp_c[n % 8] = (n < 8);
      // unused command bits are sent as ones on purpose
      wr(OFS_CTRL, {4'b0111, 3'(n % 8), 1'(n < 8)});
      chk({16'h0, pin_out.c}, {16'h0, exp_c});
    end
    chk(pin_oe, 24'hFFFFFF);
    wr(OFS_CTRL, 8'h88);
    chk(pin_oe, 24'h0FFFFF);
    chk(pin_out, 24'h0);
    wr(OFS_CTRL, 8'h86);
    ext_en.b = 8'hFF;
    ext_val.b = 8'hC3;
    ext_en.c[2] = 1'b1;
    ext_val.c[2] = 1'b1;
    wr(OFS_IRQ_SEL, 8'h02);
    wr(OFS_IRQ_GATE, 8'h04);
    chk({23'h0, irq_oe}, 24'h1);
    for (int k = 0; k < 2; k++) begin
      ext_val.c[2] = 1'b0;
      repeat (2) @(negedge clock);
      ext_val.c[2] = 1'b1;
      repeat (8) @(negedge clock);
      chk({23'h0, irq}, {23'h0, 1'(k)});
      if (k == 0) begin
        rd(OFS_PORT_B, q);
        chk({16'h0, q}, 24'hC3);
        wr(OFS_CTRL, 8'h05);
        ext_val.b = 8'h96;
      end
    end
    wr(OFS_IRQ_SEL, 8'h01);
    chk({23'h0, irq}, 24'h0);
    wr(OFS_IRQ_SEL, 8'h02);
    chk({23'h0, irq}, 24'h1);
    wr(OFS_IRQ_GATE, 8'h00);
    chk({23'h0, irq_oe}, 24'h0);
    wr(OFS_IRQ_GATE, 8'h04);
    rd(OFS_PORT_B, q);
    chk({16'h0, q}, 24'h96);
    repeat (4) @(negedge clock);
    chk({23'h0, irq}, 24'h0);
    // group A strobed input, first without its internal enable
    wr(OFS_CTRL, 8'hB0);
    ext_val.a = 8'h3E;
    ext_en.c[PC_STB_A] = 1'b1;
    ext_val.c[PC_STB_A] = 1'b1;
    wr(OFS_IRQ_SEL, 8'h01);
    pulse(PC_STB_A);
    chk({23'h0, irq}, 24'h0);
    chk({23'h0, pin_out.c[PC_IBF_A]}, 24'h1);
    wr(OFS_CTRL, 8'h09);
    chk({23'h0, irq}, 24'h1);
    chk({23'h0, pin_out.c[PC_SERVICE_REQUEST_LINE_A]}, 24'h1);
    rd(OFS_PORT_A, q);
    chk({16'h0, q}, 24'h3E);
    repeat (4) @(negedge clock);
    chk({23'h0, irq}, 24'h0);
    // clock enable low: a write must leave no trace
    ce = 1'b0;
    wr(OFS_PORT_B, 8'h5A);
    ce = 1'b1;
    rd(OFS_PORT_B, q);
    chk({16'h0, q}, 24'h00);
    // reset in mid-run drops every drive and the interrupt selects
    rst_n = 1'b0;
    @(negedge clock);
    chk(pin_oe, 24'h0);
    chk({23'h0, irq_oe}, 24'h0);
    rst_n = 1'b1;
    wr(OFS_IRQ_GATE, 8'h04);
    chk({23'h0, irq_oe}, 24'h1);
    chk({23'h0, irq}, 24'h0);
    conclude();
  end
endmodule : tb_top
